// ===== rtl/fm_ctl.sv
`default_nettype none
`include "fm_map.svh"
// ****************************************
// controller end: init then field streaming
// ****************************************
module fm_ctl
   import fm_pkg::*;
(
   input  wire logic     clock,                // single system clock
   input  wire logic     srst,                 // sync reset, active high
   fm_if.ctl             link,                 // memory side
   input  wire logic     in_valid,             // user write byte present
   input  wire fm_data_t in_data,              // user write byte
   input  wire logic     in_mask,              // high stores byte
   input  wire logic     field_start,          // pulse: begin new field
   input  wire logic     want_new,             // high: read new field
   output logic          ready,                // init done
   output logic          out_valid,            // read byte valid
   output fm_data_t      out_data              // read byte
);
   fm_state_e st_r, st_nxt;                    // controller state
   fm_cnt_t   cnt_r, cnt_nxt;                  // general counter
   fm_cnt_t   gap_r, gap_nxt;                  // cycles since write reset
   logic      pass_r, pass_nxt;                // first init pass done
   logic      wrst_r, wrst_nxt;                // write reset drive
   logic      rrst_r, rrst_nxt;                // read reset drive
   logic      rpend_r, rpend_nxt;              // read reset pending
   logic      rdq_r, rdq_nxt;                  // read advance driven this cycle
   logic      rdv_r, rdv_nxt;                  // advance landed, byte in memory reg
   logic      ready_nxt;

   // sequencing
   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      pass_nxt  = pass_r;
      wrst_nxt  = 1'b0;
      rrst_nxt  = 1'b0;
      rpend_nxt = rpend_r;
      ready_nxt = ready;
      gap_nxt   = (gap_r == '1) ? gap_r : fm_cnt_t'(gap_r + 1'b1);
      unique case (st_r)
         FM_PWR: begin
            cnt_nxt = fm_cnt_t'(cnt_r + 1'b1);
            if (cnt_r == fm_cnt_t'(`FM_PWR_CYC - 1)) begin
               cnt_nxt = '0;
               st_nxt  = FM_INIT;              // leading reset
            end
         end
         FM_DUMMY: begin                       // both ports together
            cnt_nxt = fm_cnt_t'(cnt_r + 1'b1);
            if (cnt_r == fm_cnt_t'(`FM_DUMMY_CYC - 1)) begin
               cnt_nxt = '0;
               st_nxt  = FM_INIT;
            end
         end
         FM_INIT: begin
            wrst_nxt = 1'b1;
            rrst_nxt = 1'b1;
            st_nxt   = FM_GAP;
         end
         FM_GAP: begin
            cnt_nxt = fm_cnt_t'(cnt_r + 1'b1);
            if (cnt_r == fm_cnt_t'(`FM_RST_LOW - 1)) begin
               cnt_nxt  = '0;
               pass_nxt = 1'b1;
               st_nxt   = pass_r ? FM_RUN : FM_DUMMY;
            end
         end
         FM_RUN: begin
            ready_nxt = 1'b1;
            // writes in the reset cycle are dropped by the memory, so not counted
            cnt_nxt   = (in_valid && !wrst_r && cnt_r != '1) ? fm_cnt_t'(cnt_r + 1'b1) : cnt_r;
            if (field_start && !wrst_r && cnt_r >= fm_cnt_t'(`FM_DUMMY_CYC)) begin
               wrst_nxt  = 1'b1;
               cnt_nxt   = '0;
               gap_nxt   = '0;
               rpend_nxt = 1'b1;
               if (!want_new) begin            // read reset right away
                  rrst_nxt  = 1'b1;
                  rpend_nxt = 1'b0;
               end
            end else if (rpend_r && gap_r >= fm_cnt_t'(`FM_NEW_MIN)) begin
               rrst_nxt  = 1'b1;
               rpend_nxt = 1'b0;
            end
         end
         default: st_nxt = FM_PWR;
      endcase
   end

   // read stream: old field reads in lockstep from its reset, so each location
   // is read no later than the edge that overwrites it; new field waits for
   // its delayed read reset
   always_comb begin
      rdq_nxt = ready && !rpend_nxt;
      rdv_nxt = rdq_r && !rrst_r;              // reset cycle returns no byte
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st_r      <= FM_PWR;
         cnt_r     <= '0;
         gap_r     <= '0;
         pass_r    <= 1'b0;
         wrst_r    <= 1'b0;
         rrst_r    <= 1'b0;
         rpend_r   <= 1'b0;
         rdq_r     <= 1'b0;
         rdv_r     <= 1'b0;
         ready     <= 1'b0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         st_r      <= st_nxt;
         cnt_r     <= cnt_nxt;
         gap_r     <= gap_nxt;
         pass_r    <= pass_nxt;
         wrst_r    <= wrst_nxt;
         rrst_r    <= rrst_nxt;
         rpend_r   <= rpend_nxt;
         rdq_r     <= rdq_nxt;
         rdv_r     <= rdv_nxt;
         ready     <= ready_nxt;
         out_valid <= rdv_r;                   // paired with out_data below
         out_data  <= link.read_data;
      end
   end

   // dummy cycles clock both pointers, data masked off
   assign link.write_pointer_reset = wrst_r;
   assign link.read_pointer_reset  = rrst_r;
   assign link.write_enable        = (st_r == FM_DUMMY) || (ready && in_valid);
   assign link.write_mask_enable   = ready && in_mask;
   assign link.write_data          = in_data;
   assign link.read_advance_enable = (st_r == FM_DUMMY) || rdq_r;
   assign link.read_output_enable  = 1'b1;
endmodule : fm_ctl
`default_nettype wire

// ===== rtl/fm_map.svh
`ifndef FM_MAP_SVH
`define FM_MAP_SVH
// ****************************************
// field memory constants
// ****************************************
`define FM_DATA_W        8
`define FM_ADDR_W        10
`define FM_DEPTH         1024
`define FM_DUMMY_CYC     80
`define FM_OLD_WIN       70
`define FM_NEW_MIN       600
`define FM_LAG_MIN       600
`define FM_RST_LOW       2
`define FM_PWR_US        100
`define FM_CLK_MHZ       50
`define FM_PWR_CYC       (`FM_PWR_US * `FM_CLK_MHZ)
`define FM_CNT_W         13
`endif

// ===== rtl/fm_pkg.sv
`default_nettype none
`include "fm_map.svh"
// ****************************************
// field memory types
// ****************************************
package fm_pkg;
   typedef logic [`FM_DATA_W-1:0] fm_data_t;   // one pixel byte
   typedef logic [`FM_ADDR_W-1:0] fm_addr_t;   // pointer value
   typedef logic [`FM_CNT_W-1:0]  fm_cnt_t;    // controller counters
   typedef enum logic [2:0] {
      FM_PWR   = 3'h0,                         // supply settle wait
      FM_DUMMY = 3'h1,                         // dummy clocking
      FM_INIT  = 3'h2,                         // pointer reset pulse
      FM_GAP   = 3'h3,                         // reset low spacing
      FM_RUN   = 3'h4                          // field streaming
   } fm_state_e;
endpackage : fm_pkg
`default_nettype wire

// ===== rtl/fm_if.sv
`default_nettype none
// ****************************************
// link between controller and field memory
// ****************************************
interface fm_if;
   import fm_pkg::*;
   logic     write_pointer_reset;    // write pointer clear request
   logic     write_enable;           // write strobe, advances pointer
   logic     write_mask_enable;      // stores data when high
   fm_data_t write_data;             // data in
   logic     read_pointer_reset;     // read pointer clear request
   logic     read_advance_enable;    // advances read pointer
   logic     read_output_enable;     // data output gate
   fm_data_t read_data;              // data out
   logic     read_data_oe_n;         // low while memory drives read_data
   modport mem (input write_pointer_reset, write_enable, write_mask_enable, write_data,
                input read_pointer_reset, read_advance_enable, read_output_enable,
                output read_data, read_data_oe_n);
   modport ctl (output write_pointer_reset, write_enable, write_mask_enable, write_data,
                output read_pointer_reset, read_advance_enable, read_output_enable,
                input read_data, read_data_oe_n);
endinterface : fm_if
`default_nettype wire

// ===== rtl/fm_mem.sv
`default_nettype none
`include "fm_map.svh"
module fm_mem
   import fm_pkg::*;
(
   input  wire logic clock,                    // single system clock
   input  wire logic srst,                     // sync reset, active high
   fm_if.mem         link,                     // controller side
   output logic      write_valid,              // write pointer initialized
   output logic      read_valid                // read pointer initialized
);
   // ****************************************
   // storage and pointers
   // ****************************************
   fm_data_t mem_r [`FM_DEPTH];                // field storage
   fm_addr_t wptr_r, wptr_nxt;                 // write pointer
   fm_addr_t rptr_r, rptr_nxt;                 // read pointer
   logic     wvld_nxt, rvld_nxt;               // pointer valid flags
   fm_data_t rdat_r, rdat_nxt;                 // output register
   logic     oen_r, oen_nxt;                   // output enable, low drives

   // write pointer: reset wins, enables ignored then
   always_comb begin
      wptr_nxt = wptr_r;
      wvld_nxt = write_valid;
      if (link.write_pointer_reset) begin
         wptr_nxt = '0;
         wvld_nxt = 1'b1;
      end else if (link.write_enable) begin
         wptr_nxt = fm_addr_t'(wptr_r + 1'b1);
      end
   end

   // read pointer and output data path
   always_comb begin
      rptr_nxt = rptr_r;
      rvld_nxt = read_valid;
      rdat_nxt = rdat_r;
      oen_nxt  = ~link.read_output_enable;
      if (link.read_pointer_reset) begin
         rptr_nxt = '0;
         rvld_nxt = 1'b1;
      end else if (link.read_advance_enable) begin
         rdat_nxt = mem_r[rptr_r];
         rptr_nxt = fm_addr_t'(rptr_r + 1'b1);
      end
   end

   // register stage; storage has no reset
   always_ff @(posedge clock) begin
      if (srst) begin
         wptr_r      <= '0;
         rptr_r      <= '0;
         write_valid <= 1'b0;
         read_valid  <= 1'b0;
         rdat_r      <= '0;
         oen_r       <= 1'b1;
      end else begin
         wptr_r      <= wptr_nxt;
         rptr_r      <= rptr_nxt;
         write_valid <= wvld_nxt;
         read_valid  <= rvld_nxt;
         rdat_r      <= rdat_nxt;
         oen_r       <= oen_nxt;
      end
   end

   // write into array when enabled and not masked
   always_ff @(posedge clock) begin
      if (!link.write_pointer_reset && link.write_enable && link.write_mask_enable) begin
         mem_r[wptr_r] <= link.write_data;
      end
   end

   assign link.read_data      = rdat_r;
   assign link.read_data_oe_n = oen_r;
endmodule : fm_mem
`default_nettype wire

// ===== bench/fm_checker.sv
`default_nettype none
`include "fm_map.svh"
// ****
// link protocol checks
// ****
module fm_checker
   import fm_pkg::*;
(
   input wire logic clock,                // system clock
   input wire logic srst,                 // sync reset
   input wire logic write_pointer_reset,  // write reset
   input wire logic write_enable,         // write strobe
   input wire logic read_pointer_reset    // read reset
);
   timeunit 1ns;
   timeprecision 1ps;
   fm_cnt_t   cyc_r;                      // cycles since reset
   fm_cnt_t   wcyc_r;                     // cycles since write reset
   fm_cnt_t   rcyc_r;                     // cycles since read reset
   fm_cnt_t   wen_r;                      // enabled writes since write reset
   logic      wq_r, rq_r;                 // delayed resets
   logic      wseen_r, rseen_r;           // one reset seen
   wire logic w_rise = write_pointer_reset & ~wq_r;
   wire logic r_rise = read_pointer_reset & ~rq_r;
   // saturating increment
   function automatic fm_cnt_t inc(input fm_cnt_t c);
      return (&c) ? c : c + 1'b1;
   endfunction : inc
   // helper counters
   always_ff @(posedge clock) begin
      if (srst) begin
         {cyc_r, wcyc_r, rcyc_r, wen_r} <= '0;
         {wq_r, rq_r, wseen_r, rseen_r} <= '0;
      end else begin
         cyc_r   <= inc(cyc_r);
         wcyc_r  <= w_rise ? fm_cnt_t'(1) : inc(wcyc_r);
         rcyc_r  <= r_rise ? fm_cnt_t'(1) : inc(rcyc_r);
         wen_r   <= w_rise ? fm_cnt_t'(0) : (write_enable ? inc(wen_r) : wen_r);
         wq_r    <= write_pointer_reset;
         rq_r    <= read_pointer_reset;
         wseen_r <= wseen_r | w_rise;
         rseen_r <= rseen_r | r_rise;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   property p_pwr_w; w_rise |-> cyc_r >= `FM_PWR_CYC; endproperty
   a_pwr_w: assert property (p_pwr_w) else $error("early write reset");
   property p_pwr_r; r_rise |-> cyc_r >= `FM_PWR_CYC; endproperty
   a_pwr_r: assert property (p_pwr_r) else $error("early read reset");
   property p_pre; cyc_r < `FM_PWR_CYC |-> !write_enable; endproperty
   a_pre: assert property (p_pre) else $error("write during supply wait");
   property p_wspan; w_rise && wseen_r |-> wcyc_r >= `FM_DUMMY_CYC; endproperty
   a_wspan: assert property (p_wspan) else $error("write resets too close");
   property p_rspan; r_rise && rseen_r |-> rcyc_r >= `FM_DUMMY_CYC; endproperty
   a_rspan: assert property (p_rspan) else $error("read resets too close");
   property p_wgap; $fell(write_pointer_reset) |-> ##1 !write_pointer_reset; endproperty
   a_wgap: assert property (p_wgap) else $error("write reset low too short");
   property p_wfield; w_rise && wseen_r |-> wen_r >= `FM_DUMMY_CYC; endproperty
   a_wfield: assert property (p_wfield) else $error("too few writes in field");
   property p_rgap; $fell(read_pointer_reset) |-> ##1 !read_pointer_reset; endproperty
   a_rgap: assert property (p_rgap) else $error("read reset low too short");
   property p_space;
      r_rise && !w_rise |-> wcyc_r <= `FM_OLD_WIN + 1 || wcyc_r >= `FM_NEW_MIN;
   endproperty
   a_space: assert property (p_space) else $error("reset spacing undetermined");
   c_old: cover property (r_rise && w_rise);
   c_new: cover property (r_rise && wcyc_r >= `FM_NEW_MIN);
   c_init: cover property (w_rise && wseen_r);
endmodule : fm_checker
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
// ****
// field memory bench
// ****
module tb import fm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic     clock, srst;                 // clock and reset
   logic     in_valid, in_mask;           // user write side
   logic     field_start, want_new;       // field control
   logic     ready, out_valid;            // controller status
   logic     write_valid, read_valid;     // pointer status
   fm_data_t in_data, out_data;           // user bytes
   int       error_cnt, samples_checked;  // counters
   fm_if link();
   fm_ctl i_fm_ctl(.clock, .srst, .link, .in_valid, .in_data, .in_mask, .field_start,
                   .want_new, .ready, .out_valid, .out_data);
   fm_mem i_fm_mem(.clock, .srst, .link, .write_valid, .read_valid);
   fm_checker i_fm_checker(.clock, .srst, .write_pointer_reset(link.write_pointer_reset),
      .write_enable(link.write_enable), .read_pointer_reset(link.read_pointer_reset));
   // compare tasks
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_byte(input fm_data_t got, input fm_data_t exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic wrap_up();
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // wait for init, pointers valid
   task automatic t_init();
      chk_bit(write_valid, 1'b0);
      for (int k = 0; k < 6000 && ready !== 1'b1; k++) @(posedge clock);
      #1;
      chk_bit(ready, 1'b1);
      chk_bit(write_valid, 1'b1);
      chk_bit(read_valid, 1'b1);
      @(posedge clock);
   endtask : t_init
   // one byte a cycle, mask low on bytes 4..7 when msk
   task automatic put_bytes(input fm_data_t wb, input int n, input logic msk);
      for (int i = 0; i < n; i++) begin
         in_valid <= 1'b1;
         in_data  <= fm_data_t'(wb + i);
         in_mask  <= !(msk && i >= 4 && i < 8);
         @(posedge clock);
      end
      in_valid <= 1'b0;
   endtask : put_bytes
   // start a field: write it, read back 100 bytes of the new field (nw high) or the old field from read reset
   task automatic run_field(input logic nw, input fm_data_t wb, input int n,
                            input logic msk, input fm_data_t eb, input fm_data_t ab);
      want_new    <= nw;
      field_start <= 1'b1;
      @(posedge clock);
      field_start <= 1'b0;
      fork
         begin
            do @(posedge clock); while (link.write_pointer_reset !== 1'b1);
            put_bytes(wb, n, msk);
         end
         begin
            do @(posedge clock); while (link.read_pointer_reset !== 1'b1);
            // reset edge seen; advance next edge, memory reg, then out_data
            repeat (2) @(posedge clock);
            for (int i = 0; i < 100; i++) begin
               #1;
               chk_bit(out_valid, 1'b1);
               chk_byte(out_data, fm_data_t'(((i >= 4 && i < 8) ? ab : eb) + i));
               @(posedge clock);
            end
         end
      join
   endtask : run_field
   // clock, 20 ns
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // watchdog, about three times the run
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end
   // main sequence
   initial begin
      {srst, in_valid, in_mask, field_start, want_new} = 5'h10;
      in_data = 8'h00;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      t_init();
      put_bytes(8'h10, 100, 1'b0);
      run_field(1'b0, 8'h80, 100, 1'b1, 8'h10, 8'h10);
      run_field(1'b0, 8'h30, 100, 1'b0, 8'h80, 8'h10);
      run_field(1'b1, 8'h40, 700, 1'b0, 8'h40, 8'h40);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
